// ===== host_strobe_model.sv
// host model that keeps the watchdog strobe moving while enabled
`timescale 1ns/1ps
module host_strobe_model #(
    parameter int HALF_CLK = 40
) (
    input wire logic clk_i,
    input wire logic en_i,
    output logic strobe_o
);
    int cnt = 0;
    initial strobe_o = 1'b0;
    // toggle well inside the shortest watchdog period; stopping it starves the timer
    always @(posedge clk_i) begin
        cnt <= (cnt == HALF_CLK - 1) ? 0 : cnt + 1;
        if (en_i && cnt == HALF_CLK - 1) begin
            strobe_o <= ~strobe_o;
        end
    end
endmodule

// ===== pin_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s st;
    sync_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // s1 feeds only s2; the agreement check looks at s2 and s3
    always_comb begin
        next_st = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // per bit, so a bit still settling never holds back its neighbours
        next_st.q = (st.q & (st.s2 ^ st.s3)) | (st.s3 & ~(st.s2 ^ st.s3));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.q;

endmodule

// ===== rtc_sup_pkg.sv
// constants, field layouts and carrier types for the rtc supervisor block
package rtc_sup_pkg;

    // clock and timebase
    localparam int CLK_PERIOD_NS = 25;
    localparam longint TB_HZ = 32768;

    // host address must rest on the flags register this long before a read clears it
    localparam int ADDR_HOLD_NS = 50;
    localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register offsets
    localparam logic [3:0] RATE_CONTROL_OFS = 4'hb;
    localparam logic [3:0] INTERRUPT_ENABLES_OFS = 4'hc;
    localparam logic [3:0] EVENT_FLAGS_OFS = 4'hd;
    localparam logic [3:0] CLOCK_CONTROL_OFS = 4'he;

    // rate_control fields
    localparam int WD_SEL_LSB = 4;
    localparam int RS_LSB = 0;
    localparam logic [2:0] WD_SEL_RESET = 3'h0;
    localparam logic [3:0] RS_NONE = 4'h0;

    // interrupt_enables / event_flags bit positions (alarm, periodic, powerfail, extra)
    localparam int ALARM_BIT = 3;
    localparam int PERIODIC_BIT = 2;
    localparam int PWRFAIL_BIT = 1;
    localparam int ALARM_BACKUP_BIT = 0;
    localparam int BATT_VALID_BIT = 0;

    // clock_control fields
    localparam int INHIBIT_BIT = 3;
    localparam int OSC_RUN_BIT = 2;
    localparam logic [3:0] CLOCK_CONTROL_RESET = 4'h4;

    // watchdog periods, each in its own unit, then in timebase ticks
    localparam longint WD_DEFAULT_MS = 1500;
    localparam longint WD_LONG_MS = 3000;
    localparam longint WD_BASE_NS = 23437500;
    localparam logic [16:0] WD_DEFAULT_TICKS = 17'(WD_DEFAULT_MS * TB_HZ / 1000);
    localparam logic [16:0] WD_LONG_TICKS = 17'(WD_LONG_MS * TB_HZ / 1000);
    localparam logic [16:0] WD_BASE_TICKS = 17'(WD_BASE_NS * TB_HZ / 1000000000);
    localparam int WD_PULSE_DIV = 6;
    localparam logic [2:0] WD_SEL_LONG = 3'h7;

    // ce gating modes
    typedef enum logic [1:0] {
        CE_PASS,
        CE_FINISH,
        CE_BLOCK,
        CE_RECOVER
    } ce_mode_e;

    // pins sampled from outside the clock domain
    typedef struct packed {
        logic timebase;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [3:0] addr;
        logic [7:0] data;
        logic ce_in_n;
        logic pwr_fail;
        logic backup;
        logic battery_valid;
        logic strobe;
        logic strobe_open;
        logic alarm;
    } pins_s;

    // safe pin values while the synchroniser fills: bus idle, supply failed
    localparam pins_s PINS_IDLE = '{
        timebase: 1'b0, cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 4'h0, data: 8'h00,
        ce_in_n: 1'b1, pwr_fail: 1'b1, backup: 1'b0, battery_valid: 1'b0,
        strobe: 1'b0, strobe_open: 1'b1, alarm: 1'b0
    };

endpackage

// ===== rtc_supervisor_control.sv
// supervisory, power-fail, watchdog and interrupt logic of the rtc
`timescale 1ns/1ps
// Contract
// - with inhibit set software writes time; clearing it loads counters, updates resume.
// - oscillator-run 1 keeps clock in backup; 0 halts it in backup.
// - above switchover the clock always runs.
// - below power-fail threshold writes blocked; block lasts recovery time afterwards.
// - on power-fail the sram select output goes inactive regardless of input.
// - access in progress may finish, but is cut after the grace time.
// - after power returns select stays inactive for the select recovery time.
// - with valid power the select input passes through.
// - backup cell stays isolated until supply first rises above threshold.
// - strobe idle longer than timeout asserts fault and reset; default 1.5 s.
// - any strobe edge or pulse restarts the watchdog; host must toggle.
// - watchdog selector kept over power cycles; 000 without battery. Code resets it to 000 on every rst_i, battery or not.
// - first period after watchdog reset equals programmed timeout.
// - floating strobe input disables the watchdog.
// - watchdog off, fault high, on power-fail, backup or open strobe.
// - timeout gives reset pulse of pulse width; fault low until next edge.
// - idle strobe gives repeated reset pulses once per watchdog period.
// - each event sets its flag; interrupt requested only when enabled.
// - flags read clears all flags and releases interrupt, after 50 ns address hold.
// - periodic rate selector sets periodic flag; its enable routes it out.
// - alarm event recurs at rates set by the external alarm comparison.
// - power-fail raises interrupt when its enable is set.
// - rate code 0 off, 1 is one tick, each code doubles up to 15.
// - watchdog 000 1.5 s, 001 23.4375 ms doubling, 111 3 s; pulse sixth.
// - power-fail interrupt enable cleared at every power-up.
module rtc_supervisor_control #(
    parameter int PROTECT_TICKS = 16,
    parameter int SEL_RECOVERY_TICKS = 16,
    parameter int RST_HOLD_TICKS = 16,
    parameter int GRACE_TICKS = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic timebase_i,
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic ce_in_n_i,
    output logic ce_out_n_o,
    input wire logic pwr_fail_i,
    input wire logic backup_i,
    input wire logic battery_valid_i,
    input wire logic watchdog_strobe_input_i,
    input wire logic strobe_open_i,
    input wire logic alarm_event_i,
    output logic watchdog_fault_output_n_o,
    output logic cpu_reset_n_o,
    output logic irq_n_o,
    output logic irq_oe_o,
    output logic cell_isolate_o,
    output logic clock_run_o,
    output logic update_transfer_inhibit_o,
    output logic load_counters_o
);

    typedef struct packed {
        logic tb_prev;
        logic alarm_prev;
        logic pwr_prev;
        logic strobe_prev;
        logic strobe_seen;
        logic [13:0] prescale;
        logic [2:0] watchdog_period_select;
        logic [3:0] periodic_rate_select;
        logic [3:0] ien;
        logic [3:1] flags;
        logic [3:0] ctrl;
        logic load;
        logic [1:0] rd_hold;
        logic clr_pend;
        logic wr_active;
        logic [3:0] wr_addr;
        logic [7:0] wr_data;
        logic [15:0] protect_cnt;
        rtc_sup_pkg::ce_mode_e ce_mode;
        logic [15:0] ce_cnt;
        logic ce_out_n;
        logic isolate;
        logic [15:0] hold_cnt;
        logic [16:0] wd_cnt;
        logic [16:0] pulse_cnt;
        logic wdo_n;
        logic reset_n;
        logic [7:0] data_out;
        logic data_oe;
        logic irq_oe;
        logic clock_run;
    } state_s;

    rtc_sup_pkg::pins_s pin_in;
    rtc_sup_pkg::pins_s pins;
    state_s st;
    state_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // every pin crosses into clk_i through four flops
    assign pin_in = '{timebase: timebase_i, cs_n: cs_n_i, we_n: we_n_i, oe_n: oe_n_i,
        addr: addr_i, data: data_i, ce_in_n: ce_in_n_i, pwr_fail: pwr_fail_i,
        backup: backup_i, battery_valid: battery_valid_i,
        strobe: watchdog_strobe_input_i, strobe_open: strobe_open_i, alarm: alarm_event_i};

    pin_sync3 #(
        .W($bits(rtc_sup_pkg::pins_s)),
        .RST_VAL(rtc_sup_pkg::PINS_IDLE)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pin_in),
        .q_o(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // watchdog period and reset pulse width per selector, in ticks
    function automatic logic [16:0] wd_period(input logic [2:0] sel);
        if (sel == rtc_sup_pkg::WD_SEL_RESET) begin
            return rtc_sup_pkg::WD_DEFAULT_TICKS;
        end else if (sel == rtc_sup_pkg::WD_SEL_LONG) begin
            return rtc_sup_pkg::WD_LONG_TICKS;
        end
        return rtc_sup_pkg::WD_BASE_TICKS << (sel - 3'h1);
    endfunction

    logic tick;
    logic rd_now;
    logic wr_now;
    logic wr_done;
    logic protect;
    logic strobe_edge;
    logic wd_enable;
    logic [16:0] period;
    logic [16:0] pulse_w;
    logic [13:0] rs_mask;
    logic [3:1] set_flags;
    logic irq_req;

    // decoded conditions shared by the next-state logic
    assign tick = pins.timebase && !st.tb_prev;
    assign rd_now = !pins.cs_n && !pins.oe_n && pins.we_n;
    assign wr_now = !pins.cs_n && !pins.we_n;
    assign wr_done = st.wr_active && !wr_now;
    assign protect = pins.pwr_fail || (st.protect_cnt != 16'h0000);
    assign strobe_edge = pins.strobe != st.strobe_prev;
    assign wd_enable = !pins.pwr_fail && !pins.backup && !pins.strobe_open;
    assign period = wd_period(st.watchdog_period_select);
    assign pulse_w = 17'(period / rtc_sup_pkg::WD_PULSE_DIV);
    assign rs_mask = 14'((15'h0001 << (st.periodic_rate_select - 4'h1)) - 15'h0001);

    // event sources for the sticky flags
    always_comb begin
        set_flags = 3'h0;
        set_flags[rtc_sup_pkg::ALARM_BIT] = pins.alarm && !st.alarm_prev;
        set_flags[rtc_sup_pkg::PERIODIC_BIT] = tick
            && (st.periodic_rate_select != rtc_sup_pkg::RS_NONE)
            && ((st.prescale & rs_mask) == rs_mask);
        set_flags[rtc_sup_pkg::PWRFAIL_BIT] = pins.pwr_fail && !st.pwr_prev;
    end

    // in backup only an alarm with the backup enable may pull the line
    always_comb begin
        if (pins.backup) begin
            irq_req = st.flags[rtc_sup_pkg::ALARM_BIT] && st.ien[rtc_sup_pkg::ALARM_BIT]
                && st.ien[rtc_sup_pkg::ALARM_BACKUP_BIT];
        end else begin
            irq_req = |(st.flags & st.ien[3:1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.tb_prev = pins.timebase;
        next_st.alarm_prev = pins.alarm;
        next_st.pwr_prev = pins.pwr_fail;
        next_st.strobe_prev = pins.strobe;
        next_st.load = 1'b0;
        if (tick) begin
            next_st.prescale = st.prescale + 14'h0001;
        end

        // writes land at the end of the strobe; data latched while it is low
        next_st.wr_active = wr_now;
        if (wr_now) begin
            next_st.wr_addr = pins.addr;
            next_st.wr_data = pins.data;
        end
        if (wr_done && !protect) begin
            case (st.wr_addr)
                rtc_sup_pkg::RATE_CONTROL_OFS: begin
                    next_st.watchdog_period_select = st.wr_data[rtc_sup_pkg::WD_SEL_LSB +: 3];
                    next_st.periodic_rate_select = st.wr_data[rtc_sup_pkg::RS_LSB +: 4];
                end
                rtc_sup_pkg::INTERRUPT_ENABLES_OFS: begin
                    next_st.ien = st.wr_data[3:0];
                end
                rtc_sup_pkg::CLOCK_CONTROL_OFS: begin
                    next_st.ctrl = st.wr_data[3:0];
                    // inhibit falling: the written time goes to the counters
                    next_st.load = st.ctrl[rtc_sup_pkg::INHIBIT_BIT]
                        && !st.wr_data[rtc_sup_pkg::INHIBIT_BIT];
                end
                default: begin
                end
            endcase
        end

        // power-up clears the power-fail enable; a concurrent write loses
        if (!pins.pwr_fail && st.pwr_prev) begin
            next_st.ien[rtc_sup_pkg::PWRFAIL_BIT] = 1'b0;
        end

        // register protection window
        if (pins.pwr_fail) begin
            next_st.protect_cnt = 16'(PROTECT_TICKS);
        end else if (tick && st.protect_cnt != 16'h0000) begin
            next_st.protect_cnt = st.protect_cnt - 16'h0001;
        end

        // read path; address must dwell on flags before the read may clear
        next_st.data_oe = rd_now && (pins.addr >= rtc_sup_pkg::RATE_CONTROL_OFS)
            && (pins.addr <= rtc_sup_pkg::CLOCK_CONTROL_OFS);
        case (pins.addr)
            rtc_sup_pkg::RATE_CONTROL_OFS:
                next_st.data_out = {1'b0, st.watchdog_period_select, st.periodic_rate_select};
            rtc_sup_pkg::INTERRUPT_ENABLES_OFS: next_st.data_out = {4'h0, st.ien};
            rtc_sup_pkg::EVENT_FLAGS_OFS:
                next_st.data_out = {4'h0, st.flags, pins.battery_valid};
            rtc_sup_pkg::CLOCK_CONTROL_OFS: next_st.data_out = {4'h0, st.ctrl};
            default: next_st.data_out = 8'h00;
        endcase
        if (rd_now && pins.addr == rtc_sup_pkg::EVENT_FLAGS_OFS) begin
            if (st.rd_hold != 2'(rtc_sup_pkg::ADDR_HOLD_CYC)) begin
                next_st.rd_hold = st.rd_hold + 2'h1;
            end else begin
                next_st.clr_pend = 1'b1;
            end
        end else begin
            next_st.rd_hold = 2'h0;
            next_st.clr_pend = 1'b0;
        end
        // clear when the read ends so the value read stays stable; a new event wins
        if (st.clr_pend && !(rd_now && pins.addr == rtc_sup_pkg::EVENT_FLAGS_OFS)) begin
            next_st.flags = set_flags;
        end else begin
            next_st.flags = st.flags | set_flags;
        end
        next_st.irq_oe = irq_req;

        // sram select gating through a power-fail cycle
        case (st.ce_mode)
            rtc_sup_pkg::CE_PASS: begin
                next_st.ce_out_n = pins.ce_in_n;
                if (pins.pwr_fail) begin
                    next_st.ce_cnt = 16'(GRACE_TICKS);
                    next_st.ce_mode = pins.ce_in_n ? rtc_sup_pkg::CE_BLOCK
                        : rtc_sup_pkg::CE_FINISH;
                    // idle select blocks at once, a running access may finish
                    next_st.ce_out_n = pins.ce_in_n;
                end
            end
            rtc_sup_pkg::CE_FINISH: begin
                next_st.ce_out_n = pins.ce_in_n;
                if (tick && st.ce_cnt != 16'h0000) begin
                    next_st.ce_cnt = st.ce_cnt - 16'h0001;
                end
                if (pins.ce_in_n || st.ce_cnt == 16'h0000) begin
                    next_st.ce_mode = rtc_sup_pkg::CE_BLOCK;
                    next_st.ce_out_n = 1'b1;
                end
            end
            rtc_sup_pkg::CE_BLOCK: begin
                next_st.ce_out_n = 1'b1;
                if (!pins.pwr_fail) begin
                    next_st.ce_cnt = 16'(SEL_RECOVERY_TICKS);
                    next_st.ce_mode = rtc_sup_pkg::CE_RECOVER;
                end
            end
            rtc_sup_pkg::CE_RECOVER: begin
                next_st.ce_out_n = 1'b1;
                if (pins.pwr_fail) begin
                    next_st.ce_mode = rtc_sup_pkg::CE_BLOCK;
                end else if (st.ce_cnt == 16'h0000) begin
                    next_st.ce_mode = rtc_sup_pkg::CE_PASS;
                end else if (tick) begin
                    next_st.ce_cnt = st.ce_cnt - 16'h0001;
                end
            end
            default: begin
                next_st.ce_mode = rtc_sup_pkg::CE_BLOCK;
                next_st.ce_out_n = 1'b1;
            end
        endcase

        // cell isolation until the first good supply
        if (!pins.pwr_fail) begin
            next_st.isolate = 1'b0;
        end

        // power-on reset hold
        if (pins.pwr_fail) begin
            next_st.hold_cnt = 16'(RST_HOLD_TICKS);
        end else if (tick && st.hold_cnt != 16'h0000) begin
            next_st.hold_cnt = st.hold_cnt - 16'h0001;
        end

        // watchdog; edges are caught every clk so short pulses count
        if (!wd_enable) begin
            next_st.wd_cnt = 17'h00000;
            next_st.pulse_cnt = 17'h00000;
            next_st.strobe_seen = 1'b0;
            next_st.wdo_n = 1'b1;
        end else begin
            if (strobe_edge) begin
                next_st.strobe_seen = 1'b1;
                next_st.wdo_n = 1'b1;
            end
            if (tick && st.pulse_cnt != 17'h00000) begin
                next_st.pulse_cnt = st.pulse_cnt - 17'h00001;
            end
            if (tick) begin
                next_st.strobe_seen = 1'b0;
                if (st.strobe_seen || strobe_edge) begin
                    next_st.wd_cnt = 17'h00000;
                end else if (st.wd_cnt + 17'h00001 >= period) begin
                    // timeout restarts the full period, so pulses repeat
                    next_st.wd_cnt = 17'h00000;
                    next_st.pulse_cnt = pulse_w;
                    next_st.wdo_n = 1'b0;
                end else begin
                    next_st.wd_cnt = st.wd_cnt + 17'h00001;
                end
            end
        end

        next_st.reset_n = !pins.pwr_fail && (st.hold_cnt == 16'h0000)
            && (st.pulse_cnt == 17'h00000);
        // oscillator stops only in backup with the run bit cleared
        next_st.clock_run = !pins.backup || st.ctrl[rtc_sup_pkg::OSC_RUN_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; selector resets to default on every rst_i, battery or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.pwr_prev <= 1'b1;
            st.watchdog_period_select <= rtc_sup_pkg::WD_SEL_RESET;
            st.ctrl <= rtc_sup_pkg::CLOCK_CONTROL_RESET;
            st.ce_mode <= rtc_sup_pkg::CE_BLOCK;
            st.ce_out_n <= 1'b1;
            st.isolate <= 1'b1;
            st.wdo_n <= 1'b1;
            st.clock_run <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops, except irq_n_o which is tied low
    assign data_o = st.data_out;
    assign data_oe_o = st.data_oe;
    assign ce_out_n_o = st.ce_out_n;
    assign watchdog_fault_output_n_o = st.wdo_n;
    assign cpu_reset_n_o = st.reset_n;
    assign irq_n_o = 1'b0;
    assign irq_oe_o = st.irq_oe;
    assign cell_isolate_o = st.isolate;
    assign clock_run_o = st.clock_run;
    assign update_transfer_inhibit_o = st.ctrl[rtc_sup_pkg::INHIBIT_BIT];
    assign load_counters_o = st.load;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wd_expire;
        wd_enable && tick && !st.strobe_seen && !strobe_edge && (st.wd_cnt + 17'h00001 >= period);
    endsequence
    sequence s_pulse_out;
        ##1 (!st.wdo_n && st.pulse_cnt == pulse_w) ##1 !cpu_reset_n_o;
    endsequence

    a_wd_timeout_reset: assert property (s_wd_expire |-> s_pulse_out)
        else $error("watchdog timeout did not raise fault and reset");
    a_wd_disable_high: assert property (!wd_enable |=> st.wdo_n && st.pulse_cnt == 17'h00000)
        else $error("watchdog active while disabled");
    a_strobe_restart: assert property (wd_enable && tick && strobe_edge |=> st.wd_cnt == 0)
        else $error("strobe edge did not restart watchdog");
    a_ce_block_fail: assert property (st.ce_mode == rtc_sup_pkg::CE_BLOCK |=> ce_out_n_o)
        else $error("sram select active during power fail");
    a_ce_pass_thru: assert property (st.ce_mode == rtc_sup_pkg::CE_PASS && !pins.pwr_fail
        |=> ce_out_n_o == $past(pins.ce_in_n))
        else $error("sram select not passed through");
    a_write_protect: assert property (wr_done && protect |=> $stable(st.ien)
        || (!$past(pins.pwr_fail) && $past(st.pwr_prev)))
        else $error("register written while protected");
    a_reset_on_fail: assert property (pins.pwr_fail |=> !cpu_reset_n_o)
        else $error("reset not low on power fail");
    a_flag_set_wins: assert property (set_flags[rtc_sup_pkg::PWRFAIL_BIT]
        |=> st.flags[rtc_sup_pkg::PWRFAIL_BIT])
        else $error("power fail flag lost");
    a_irq_gate: assert property (!pins.backup && !(|(st.flags & st.ien[3:1])) |=> !irq_oe_o)
        else $error("interrupt driven without enabled flag");
    a_osc_halt: assert property (pins.backup && !st.ctrl[rtc_sup_pkg::OSC_RUN_BIT]
        |=> !clock_run_o)
        else $error("clock not halted in backup");

endmodule

// ===== rtc_supervisor_control_bench.sv
// self-checking bench for the rtc supervisor block
`timescale 1ns/1ps
module rtc_supervisor_control_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, tb = 1'b0, cs_n = 1'b1, we_n = 1'b1, oe_n = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, rnd;
    logic data_oe, ce_in_n = 1'b1, ce_out_n, pf = 1'b1, bv = 1'b0, run = 1'b1;
    logic strobe, wdo_n, rst_n, iso, oe_d = 1'b0;
    logic bk = 1'b0, sopen = 1'b0, alm = 1'b0, irq_oe, crun, update_transfer_inhibit, ld, ld_seen = 1'b0;
    logic [7:0] exp_q [$];
    int error_cnt = 0, n_tests = 0;
    initial forever #12.5 clk_i = ~clk_i;
    // fast timebase, one tick per 8 clk, keeps watchdog periods short
    initial forever #100 tb = ~tb;
    initial begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
    rtc_supervisor_control #(.PROTECT_TICKS(2), .SEL_RECOVERY_TICKS(2), .RST_HOLD_TICKS(2),
        .GRACE_TICKS(2)) i_rtc_supervisor_control (.clk_i(clk_i), .rst_i(rst_i),
        .timebase_i(tb), .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr),
        .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe), .ce_in_n_i(ce_in_n),
        .ce_out_n_o(ce_out_n), .pwr_fail_i(pf), .backup_i(bk), .battery_valid_i(bv),
        .watchdog_strobe_input_i(strobe), .strobe_open_i(sopen), .alarm_event_i(alm),
        .watchdog_fault_output_n_o(wdo_n), .cpu_reset_n_o(rst_n), .irq_n_o(),
        .irq_oe_o(irq_oe), .cell_isolate_o(iso), .clock_run_o(crun),
        .update_transfer_inhibit_o(update_transfer_inhibit), .load_counters_o(ld));
    host_strobe_model i_host_strobe_model (.clk_i(clk_i), .en_i(run), .strobe_o(strobe));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // strobes held 8 clk each side, well past the four-flop sync
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        cs_n <= 1'b0;
        we_n <= ~wr;
        oe_n <= wr;
        if (!wr && a inside {[4'hb:4'he]}) exp_q.push_back(d);
        repeat (8) @(posedge clk_i);
        cs_n <= 1'b1;
        we_n <= 1'b1;
        oe_n <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
    // read monitor: oldest note against each new drive of the data bus
    always @(posedge clk_i) begin
        oe_d <= data_oe;
        // load is a one-cycle pulse, so remember that it came
        if (ld === 1'b1) ld_seen <= 1'b1;
        if (data_oe === 1'b1 && oe_d !== 1'b1) begin
            if (exp_q.size() == 0) check("stray drive", 8'h01, 8'h00);
            else check("read data", rdata, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h51a3a89c));
        rnd = 8'($urandom);
        repeat (4) @(posedge clk_i);
        check("rst_n", {7'h0, rst_n}, 8'h00);
        check("iso", {7'h0, iso}, 8'h01);
        rst_i <= 1'b0;
        pf <= 1'b0;
        bv <= rnd[7];
        ce_in_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        check("ce recover", {7'h0, ce_out_n}, 8'h01);
        for (int i = 0; i < 300 && rst_n !== 1'b1; i++) @(posedge clk_i);
        repeat (30) @(posedge clk_i);
        check("rst_n up", {7'h0, rst_n}, 8'h01);
        check("ce pass", {7'h0, ce_out_n}, 8'h00);
        check("iso off", {7'h0, iso}, 8'h00);
        check("irq idle", {7'h0, irq_oe}, 8'h00);
        $display("test power-up done");
        alm <= 1'b1;
        repeat (8) @(posedge clk_i);
        bus(1'b0, 4'hd, {4'h0, 3'h4, bv});
        bus(1'b0, 4'hd, {4'h0, 3'h0, bv});
        bus(1'b1, 4'hb, {1'b1, 3'h1, rnd[3:0]});
        bus(1'b0, 4'hb, {1'b0, 3'h1, rnd[3:0]});
        // periodic enable kept off so the interrupt line stays predictable
        bus(1'b1, 4'hc, {rnd[7:3], 1'b0, rnd[1:0]});
        bus(1'b0, 4'hc, {4'h0, rnd[3], 1'b0, rnd[1:0]});
        bus(1'b0, 4'hf, 8'h00);
        bus(1'b1, 4'he, 8'h08);
        check("inhibit", {7'h0, update_transfer_inhibit}, 8'h01);
        bus(1'b1, 4'he, 8'h00);
        check("load", {7'h0, ld_seen}, 8'h01);
        check("clock run", {7'h0, crun}, 8'h01);
        $display("test registers done");
        run <= 1'b0;
        for (int i = 0; i < 7000 && wdo_n !== 1'b0; i++) @(posedge clk_i);
        check("wdo low", {7'h0, wdo_n}, 8'h00);
        repeat (4) @(posedge clk_i);
        check("wd reset", {7'h0, rst_n}, 8'h00);
        repeat (950) @(posedge clk_i);
        check("pulse held", {7'h0, rst_n}, 8'h00);
        for (int i = 0; i < 300 && rst_n !== 1'b1; i++) @(posedge clk_i);
        check("pulse end", {7'h0, rst_n}, 8'h01);
        for (int i = 0; i < 7000 && rst_n !== 1'b0; i++) @(posedge clk_i);
        check("repeat pulse", {7'h0, rst_n}, 8'h00);
        check("wdo stays", {7'h0, wdo_n}, 8'h00);
        run <= 1'b1;
        for (int i = 0; i < 200 && wdo_n !== 1'b1; i++) @(posedge clk_i);
        check("wdo release", {7'h0, wdo_n}, 8'h01);
        sopen <= 1'b1;
        run <= 1'b0;
        repeat (7000) @(posedge clk_i);
        check("wd open", {6'h0, wdo_n, rst_n}, 8'h03);
        $display("test watchdog done");
        ce_in_n <= 1'b1;
        pf <= 1'b1;
        repeat (10) @(posedge clk_i);
        ce_in_n <= 1'b0;
        repeat (10) @(posedge clk_i);
        check("ce blocked", {7'h0, ce_out_n}, 8'h01);
        check("pf reset", {7'h0, rst_n}, 8'h00);
        check("wdo off", {7'h0, wdo_n}, 8'h01);
        check("irq pf", {7'h0, irq_oe}, {7'h0, rnd[1]});
        bus(1'b1, 4'hc, 8'h00);
        bus(1'b0, 4'hc, {4'h0, rnd[3], 1'b0, rnd[1:0]});
        bk <= 1'b1;
        repeat (8) @(posedge clk_i);
        check("osc halt", {7'h0, crun}, 8'h00);
        check("irq backup", {7'h0, irq_oe}, 8'h00);
        check("pending", 8'(exp_q.size()), 8'h00);
        $display("test power-fail done");
        print_verdict();
    end
endmodule
